// ===== lpf_pkg.sv
package lpf_pkg;

  // ----------------------------------------------------------------
  // Bus map and register fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] IND_OFF = 8'h04;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FMT_BIT = 2;
  localparam int CTRL_IDX_LSB = 8;
  localparam logic [2:0] IDX_BYTES = 3'h0;
  localparam logic [2:0] IDX_LINES = 3'h1;
  localparam logic [2:0] IDX_SUFFIX = 3'h3;
  localparam logic [2:0] IDX_ADDR = 3'h4;
  localparam logic [2:0] IDX_COUNT = 3'h5;
  localparam logic [2:0] IDX_OPTS = 3'h6;
  localparam logic [2:0] IDX_PAGE = 3'h7;
  localparam logic [15:0] OPTS_WMASK = 16'hDF03;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Character codes and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_FF = 8'h0C;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 18;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic caseConv;
    logic tabInhibit;
    logic rsvd13;
    logic lineWrap;
    logic vertFmtUnitPresent;
    logic npAccept;
    logic ffKeep;
    logic autoCrBit;
    logic [5:0] unused;
    logic [1:0] addrHigh;
  } lpf_opts_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] count;
  } lpf_affix_t;

  typedef struct packed {
    logic [7:0] width;
    logic [7:0] lines;
  } lpf_page_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SUFFIX = 2'b10,
    ST_DRAIN = 2'b11
  } lpf_state_t;

endpackage

// ===== lpf_fifo.sv
module lpf_fifo import lpf_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Fill side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_q;
  logic [PW:0] rdPtr_q;

  // Extra pointer bit tells full from empty when the indices meet.
  wire logic sameIdx = wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0];
  wire logic isFull = sameIdx && (wrPtr_q[PW] != rdPtr_q[PW]);
  wire logic isEmpty = wrPtr_q == rdPtr_q;
  wire logic doPush = inValid && !isFull;
  wire logic doPop = outReady && !isEmpty;

  assign inReady = !isFull;
  assign outValid = !isEmpty;
  assign outData = mem[rdPtr_q[PW-1:0]];

  // Storage is written without reset; only the pointers carry state.
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  // Pointer advance.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (PW+1)'(doPush);
      rdPtr_q <= rdPtr_q + (PW+1)'(doPop);
    end
  end

endmodule

// ===== lpf_dma_fetch.sv
module lpf_dma_fetch import lpf_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Start of a buffer.
  input wire logic start,
  input wire logic [ADDR_W-1:0] addrInit,
  input wire logic [15:0] cntInit,
  // Host memory read port.
  output logic dmaReq,
  output logic [ADDR_W-1:0] dmaAddr,
  input wire logic dmaAck,
  input wire logic [7:0] dmaData,
  // Towards the buffer.
  output logic pushValid,
  input wire logic pushReady,
  output logic [7:0] pushData,
  output logic busy
);

  logic req_q;
  logic busy_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0] cnt_q;

  // The count is negative; each fetch steps it toward zero.
  wire logic [15:0] cntNext = cnt_q + 16'h0001;
  wire logic fetched = req_q && dmaAck;

  assign dmaReq = req_q;
  assign dmaAddr = addr_q;
  assign pushValid = fetched;
  assign pushData = dmaData;
  assign busy = busy_q;

  // A request only goes out with room reserved, so the push never stalls.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      req_q <= 1'b0;
      busy_q <= 1'b0;
      addr_q <= '0;
      cnt_q <= REG_RESET;
    end else if (start) begin
      busy_q <= cntInit != REG_RESET;
      addr_q <= addrInit;
      cnt_q <= cntInit;
    end else if (fetched) begin
      req_q <= 1'b0;
      addr_q <= addr_q + ADDR_W'(1);
      cnt_q <= cntNext;
      busy_q <= cntNext != REG_RESET;
    end else if (busy_q && pushReady) begin
      req_q <= 1'b1;
    end
  end

endmodule

// ===== lpf_formatter.sv
// Design decisions made here: the register addresses and register access over Wishbone.
module lpf_formatter import lpf_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host memory read port.
  output logic dmaReq,
  output logic [ADDR_W-1:0] dmaAddr,
  input wire logic dmaAck,
  input wire logic [7:0] dmaData,
  // Printer character stream.
  output logic prtValid,
  input wire logic prtReady,
  output logic [7:0] prtData,
  output logic printDone
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte-lane merge for the 16-bit registers.
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
      input logic [15:0] wdat, input logic [1:0] sel);
    laneMerge = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
  endfunction

  // Word-address match, ignoring the byte offset bits.
  function automatic logic hitOff(input logic [7:0] adr, input logic [7:0] off);
    hitOff = adr[7:2] == off[7:2];
  endfunction

  // ----------------------------------------------------------------
  // Register storage and bus decode
  // ----------------------------------------------------------------

  logic ack_q;
  logic [31:0] rdat_q;
  logic fmtOn_q;
  logic [2:0] index_q;
  logic done_q;
  logic [15:0] cfg_q [2:7];
  logic [15:0] bytesTx_q;
  logic [15:0] lineCnt_q;
  lpf_state_t state_q;
  lpf_state_t state_d;

  // Named views of the configuration words.
  lpf_affix_t suffix;
  lpf_opts_t opts;
  lpf_page_t page;
  assign suffix = lpf_affix_t'(cfg_q[IDX_SUFFIX]);
  assign opts = lpf_opts_t'(cfg_q[IDX_OPTS]);
  assign page = lpf_page_t'(cfg_q[IDX_PAGE]);

  // Ack follows a request by one cycle; writes land on the ack edge the master sees.
  wire logic busReq = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wrReq = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  wire logic ctrlHit = hitOff(wb_adr_i, CTRL_OFF);
  wire logic indHit = hitOff(wb_adr_i, IND_OFF);
  wire logic ctrlWr = wrReq && ctrlHit;
  wire logic indWr = wrReq && indHit;
  wire logic busy = state_q != ST_IDLE;
  wire logic startReq = ctrlWr && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT];
  wire logic start = startReq && !busy;
  wire logic [15:0] wLow = wb_dat_i[15:0];

  // Control word view: index, done, format control and busy.
  wire logic [15:0] ctrlView = {5'h00, index_q, done_q, 4'h0, fmtOn_q, 1'b0, busy};

  // The index picks the indirect word that the second slot reaches.
  logic [15:0] indView;
  always_comb begin
    unique case (index_q)
      IDX_BYTES: indView = bytesTx_q;
      IDX_LINES: indView = lineCnt_q;
      default: indView = cfg_q[index_q];
    endcase
  end

  // Unmapped words read as zero and ignore writes.
  wire logic [31:0] rdSel = ctrlHit ? {16'h0000, ctrlView} :
                            indHit ? {16'h0000, indView} : BUS_ZERO;

  // Bus answer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= BUS_ZERO;
    end else begin
      ack_q <= busReq;
      rdat_q <= rdSel;
    end
  end

  // Control word: the index and format bit freeze while a buffer runs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fmtOn_q <= 1'b0;
      index_q <= IDX_BYTES;
    end else if (ctrlWr && !busy) begin
      if (wb_sel_i[0]) begin
        fmtOn_q <= wb_dat_i[CTRL_FMT_BIT];
      end
      if (wb_sel_i[1]) begin
        index_q <= wb_dat_i[CTRL_IDX_LSB +: 3];
      end
    end
  end

  // Writable indirect words; counters 0 and 1 belong to the hardware.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 2; i <= 7; i++) begin
        cfg_q[i] <= REG_RESET;
      end
    end else if (indWr && index_q >= 3'h2) begin
      cfg_q[index_q] <= laneMerge(cfg_q[index_q], wLow, wb_sel_i[1:0]) &
                        ((index_q == IDX_OPTS) ? OPTS_WMASK : 16'hFFFF);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Fetch engine and buffer
  // ----------------------------------------------------------------

  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  logic fetchBusy;
  logic popValid;
  logic popReady;
  logic [7:0] popData;

  lpf_dma_fetch u_fetch (
    .clk(clk),
    .reset(reset),
    .start(start),
    .addrInit({opts.addrHigh, cfg_q[IDX_ADDR]}),
    .cntInit(cfg_q[IDX_COUNT]),
    .dmaReq(dmaReq),
    .dmaAddr(dmaAddr),
    .dmaAck(dmaAck),
    .dmaData(dmaData),
    .pushValid(pushValid),
    .pushReady(pushReady),
    .pushData(pushData),
    .busy(fetchBusy)
  );

  lpf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  // ----------------------------------------------------------------
  // Character formatting
  // ----------------------------------------------------------------

  logic pendCr_q, pendCr_d;
  logic pendChar_q, pendChar_d;
  logic heldCr_q, heldCr_d;
  logic [7:0] lfLeft_q, lfLeft_d;
  logic [7:0] char_q, char_d;
  logic [7:0] sfxLeft_q, sfxLeft_d;
  logic [7:0] col_q;
  logic [7:0] linePos_q;
  logic prtValid_q;
  logic [7:0] prtData_q;

  // Pending output leaves in the order CR, line feeds, then the character.
  wire logic haveWork = pendCr_q || (lfLeft_q != 8'h00) || pendChar_q;
  wire logic emitFree = !prtValid_q || prtReady;
  wire logic doEmit = emitFree && haveWork;
  wire logic [7:0] emitByte = pendCr_q ? CHAR_CR :
                              (lfLeft_q != 8'h00) ? CHAR_LF : char_q;
  wire logic takeIn = (state_q == ST_RUN) && !haveWork && popValid;
  assign popReady = takeIn;

  // Classification of the incoming character.
  wire logic isCr = popData == CHAR_CR;
  wire logic isLf = popData == CHAR_LF;
  wire logic isFf = popData == CHAR_FF;
  wire logic nonPrint = popData[7];
  wire logic printable = !nonPrint && (popData >= CHAR_SPACE);
  wire logic autoCr = !opts.autoCrBit;
  // Nonprintables pass when accepted or when the vertical format unit is present.
  wire logic dropIt = nonPrint && !opts.npAccept && !opts.vertFmtUnitPresent;
  wire logic overWidth = (page.width != 8'h00) && (col_q >= page.width);
  wire logic wrapNow = opts.lineWrap && printable && overWidth;
  wire logic [7:0] toTop = (page.lines > linePos_q) ?
                           8'(page.lines - linePos_q) : 8'h01;
  wire logic dataDone = !fetchBusy && !popValid && !haveWork;

  // Next-state logic of the formatter; the bus reaches these through start and through the configuration words, which stay writable mid-buffer.
  always_comb begin
    state_d = state_q;
    pendCr_d = pendCr_q;
    pendChar_d = pendChar_q;
    heldCr_d = heldCr_q;
    lfLeft_d = lfLeft_q;
    char_d = char_q;
    sfxLeft_d = sfxLeft_q;
    if (doEmit) begin
      if (pendCr_q) begin
        pendCr_d = 1'b0;
      end else if (lfLeft_q != 8'h00) begin
        lfLeft_d = lfLeft_q - 8'h01;
      end else begin
        pendChar_d = 1'b0;
      end
    end
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_RUN;
          heldCr_d = 1'b0;
        end
      end
      ST_RUN: begin
        if (takeIn && !fmtOn_q) begin
          pendChar_d = 1'b1;
          char_d = popData;
        end else if (takeIn && dropIt) begin
          pendChar_d = 1'b0;
        end else if (takeIn && isCr && autoCr) begin
          // Hold the CR until the next character shows whether to strip it.
          heldCr_d = 1'b1;
          pendCr_d = heldCr_q;
        end else if (takeIn && (isLf || isFf)) begin
          heldCr_d = 1'b0;
          pendCr_d = autoCr;
          if (isFf && !opts.ffKeep) begin
            lfLeft_d = toTop;
          end else begin
            pendChar_d = 1'b1;
            char_d = popData;
          end
        end else if (takeIn) begin
          heldCr_d = 1'b0;
          pendCr_d = heldCr_q || (wrapNow && autoCr);
          lfLeft_d = {7'h00, wrapNow};
          pendChar_d = 1'b1;
          char_d = popData;
        end else if (dataDone && heldCr_q) begin
          // A CR left at the very end of the data is still printed.
          heldCr_d = 1'b0;
          pendCr_d = 1'b1;
        end else if (dataDone) begin
          state_d = ST_SUFFIX;
          sfxLeft_d = fmtOn_q ? suffix.count : 8'h00;
        end
      end
      ST_SUFFIX: begin
        if (!haveWork && sfxLeft_q == 8'h00) begin
          state_d = ST_DRAIN;
        end else if (!haveWork) begin
          sfxLeft_d = sfxLeft_q - 8'h01;
          if (suffix.code == 8'h00) begin
            pendCr_d = opts.autoCrBit;
            lfLeft_d = 8'h01;
          end else begin
            pendChar_d = 1'b1;
            char_d = suffix.code;
          end
        end
      end
      ST_DRAIN: begin
        // Done only once the last byte has been taken by the printer.
        if (!prtValid_q || prtReady) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Formatter state.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      pendCr_q <= 1'b0;
      pendChar_q <= 1'b0;
      heldCr_q <= 1'b0;
      lfLeft_q <= 8'h00;
      char_q <= 8'h00;
      sfxLeft_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pendCr_q <= pendCr_d;
      pendChar_q <= pendChar_d;
      heldCr_q <= heldCr_d;
      lfLeft_q <= lfLeft_d;
      char_q <= char_d;
      sfxLeft_q <= sfxLeft_d;
    end
  end

  // Output register towards the printer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prtValid_q <= 1'b0;
      prtData_q <= 8'h00;
    end else if (doEmit) begin
      prtValid_q <= 1'b1;
      prtData_q <= emitByte;
    end else if (prtReady) begin
      prtValid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Position tracking and counters
  // ----------------------------------------------------------------

  wire logic emitCr = doEmit && emitByte == CHAR_CR;
  wire logic emitLf = doEmit && emitByte == CHAR_LF;
  wire logic emitFf = doEmit && emitByte == CHAR_FF;
  wire logic emitText = doEmit && !emitByte[7] && emitByte >= CHAR_SPACE;
  wire logic lastLine = (page.lines != 8'h00) && (linePos_q + 8'h01 >= page.lines);

  // Column and line within the page follow what the printer was sent.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      col_q <= 8'h00;
      linePos_q <= 8'h00;
    end else begin
      if (emitCr) begin
        col_q <= 8'h00;
      end else if (emitText && col_q != 8'hFF) begin
        col_q <= col_q + 8'h01;
      end
      if (emitFf || (emitLf && lastLine)) begin
        linePos_q <= 8'h00;
      end else if (emitLf) begin
        linePos_q <= linePos_q + 8'h01;
      end
    end
  end

  // Counters restart with each buffer; the done flag marks completion.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bytesTx_q <= REG_RESET;
      lineCnt_q <= REG_RESET;
      done_q <= 1'b0;
    end else if (start) begin
      bytesTx_q <= REG_RESET;
      lineCnt_q <= REG_RESET;
      done_q <= 1'b0;
    end else begin
      if (fmtOn_q ? doEmit : pushValid) begin
        bytesTx_q <= bytesTx_q + 16'h0001;
      end
      if (emitLf) begin
        lineCnt_q <= lineCnt_q + 16'h0001;
      end
      if (state_q == ST_DRAIN && state_d == ST_IDLE) begin
        done_q <= 1'b1;
      end
    end
  end

  assign prtValid = prtValid_q;
  assign prtData = prtData_q;
  assign printDone = done_q;

endmodule

// ===== lpf_formatter_chk.sv
module lpf_formatter_chk import lpf_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Fetch and print sides.
  input wire logic dmaReq,
  input wire logic [ADDR_W-1:0] dmaAddr,
  input wire logic dmaAck,
  input wire logic prtValid,
  input wire logic prtReady,
  input wire logic [7:0] prtData,
  input wire logic printDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Shared clocking and sequences
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence busTake;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // A fetch, its release, and the very next fetch.
  sequence fetchStep;
    dmaReq && dmaAck ##1 !dmaReq ##1 dmaReq;
  endsequence
  // ----
  // Checks
  // ----
  ack_once_a: assert property (busTake |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse one cycle after take");
  unmapped_zero_a: assert property ((busTake and (!wb_we_i && wb_adr_i[7:3] != 5'h00))
    |=> wb_dat_o == BUS_ZERO) else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  fetch_hold_a: assert property (dmaReq && !dmaAck |=> dmaReq && $stable(dmaAddr))
    else $error("fetch request changed before ack");
  fetch_drop_a: assert property (dmaReq && dmaAck |=> !dmaReq)
    else $error("fetch request held after ack");
  addr_step_a: assert property (fetchStep |-> dmaAddr == $past(dmaAddr, 2) + 18'h00001)
    else $error("fetch address did not step by one");
  print_hold_a: assert property (prtValid && !prtReady |=> prtValid && $stable(prtData))
    else $error("printer byte dropped before taken");
  done_last_a: assert property ($rose(printDone) |-> !prtValid && !dmaReq)
    else $error("done raised with work pending");
  done_hold_a: assert property (printDone && !(wb_cyc_i && wb_stb_i && wb_we_i)
    |=> printDone) else $error("done fell without a write");
endmodule

bind lpf_formatter lpf_formatter_chk u_chk (.clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .dmaReq, .dmaAddr, .dmaAck,
  .prtValid, .prtReady, .prtData, .printDone);

// ===== lpf_printer_model.sv
module lpf_printer_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Pace selection.
  input wire logic slow,
  // Character stream.
  input wire logic prtValid,
  input wire logic [7:0] prtData,
  output logic prtReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pace_q;
  logic [7:0] got [$];
  // A slow printer takes one byte in four cycles, so the buffer backs up.
  assign prtReady = slow ? (pace_q == 2'h0) : 1'b1;
  // Every byte taken on a handshake edge is kept in order.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pace_q <= 2'h0;
    end else begin
      pace_q <= pace_q + 2'h1;
      if (prtValid && prtReady) got.push_back(prtData);
    end
  end
endmodule

// ===== lpf_formatter_bench.sv
module lpf_formatter_bench import lpf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, wbCyc, wbStb, wbWe, wbAck, dmaReq, dmaAck, prtValid, prtReady;
  logic printDone, slow, fmt;
  logic [7:0] wbAdr, dmaData, prtData;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [3:0] wbSel;
  logic [ADDR_W-1:0] dmaAddr;
  logic [7:0] mem [logic [17:0]];
  logic [7:0] none [$];
  logic [7:0] raw [$];
  int bad_count, checks_done;

  // ----
  // Design and far side
  // ----
  lpf_formatter u_lpf_formatter (.clk(clk), .reset(reset), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .dmaReq(dmaReq),
    .dmaAddr(dmaAddr), .dmaAck(dmaAck), .dmaData(dmaData), .prtValid(prtValid),
    .prtReady(prtReady), .prtData(prtData), .printDone(printDone));
  lpf_printer_model u_lpf_printer_model (.clk(clk), .reset(reset), .slow(slow),
    .prtValid(prtValid), .prtData(prtData), .prtReady(prtReady));

  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Host memory answers one cycle late; released data toggles so stale bytes never match.
  always @(posedge clk) begin
    if (reset) begin
      dmaAck <= 1'b0;
      dmaData <= 8'h00;
    end else if (dmaReq && !dmaAck) begin
      dmaAck <= 1'b1;
      dmaData <= mem[dmaAddr];
    end else begin
      dmaAck <= 1'b0;
      dmaData <= ~dmaData;
    end
  end

  // ----
  // Tasks
  // ----
  task wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task stop(input string what);
    bad_count++;
    $display("Error %s wait expired", what);
    wrap_up();
  endtask

  task chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 20) stop("bus ack");
  endtask

  // Select an indirect register, then access it.
  task ind(input logic [2:0] i, input logic w, input logic [15:0] d);
    wb(CTRL_OFF, 1'b1, {5'h00, i, 5'h00, fmt, 2'h0});
    wb(IND_OFF, w, d);
  endtask

  // Load a buffer, print it, and judge the stream and the byte count.
  task run(input logic f, input logic [15:0] sfx, input logic [15:0] opt,
    input logic [15:0] page, input logic [7:0] dq[$], input logic [7:0] xq[$],
    input logic [15:0] cnt);
    int n;
    fmt = f;
    ind(IDX_SUFFIX, 1'b1, sfx);
    ind(IDX_ADDR, 1'b1, 16'h1234);
    ind(IDX_COUNT, 1'b1, -16'(dq.size()));
    ind(IDX_OPTS, 1'b1, opt | 16'h0002);
    ind(IDX_PAGE, 1'b1, page);
    foreach (dq[k]) mem[18'h21234 + 18'(k)] = dq[k];
    u_lpf_printer_model.got.delete();
    wb(CTRL_OFF, 1'b1, {13'h0000, f, 2'h1});
    n = 0;
    repeat (2) @(posedge clk);
    while (printDone !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) stop("print done");
    chk_val("stream length", xq.size(), u_lpf_printer_model.got.size());
    foreach (xq[k]) chk_val("printed byte", xq[k], u_lpf_printer_model.got[k]);
    ind(IDX_BYTES, 1'b0, 16'h0000);
    chk_val("bytes sent", {16'h0000, cnt}, rd);
  endtask

  // Reset values, write mask, index selection and an unmapped word.
  task t_regs;
    for (int i = 3; i < 8; i++) begin
      ind(3'(i), 1'b0, 16'h0000);
      chk_val("reset value", 32'h0000_0000, rd);
    end
    ind(IDX_OPTS, 1'b1, 16'hFFFF);
    ind(IDX_OPTS, 1'b0, 16'h0000);
    chk_val("options", {16'h0000, OPTS_WMASK}, rd);
    ind(IDX_SUFFIX, 1'b1, 16'hA55A);
    ind(IDX_ADDR, 1'b1, 16'h5AA5);
    ind(IDX_SUFFIX, 1'b0, 16'h0000);
    chk_val("indirect select", 32'h0000_A55A, rd);
    wb(8'h08, 1'b1, 16'hFFFF);
    wb(8'h08, 1'b0, 16'h0000);
    chk_val("unmapped read", BUS_ZERO, rd);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    reset = 1'b1;
    {wbCyc, wbStb, wbWe, slow, fmt} = 5'h00;
    wbAdr = 8'h00;
    wbDatI = 32'h0000_0000;
    wbSel = 4'hF;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    // Line position is still at top after reset, so the feed count is known.
    run(1'b1, 16'h0000, 16'h0100, 16'h0003, '{8'h0C},
      '{8'h0A, 8'h0A, 8'h0A}, 16'h0003);
    run(1'b1, 16'h5803, 16'h0300, 16'h0000, '{8'h41, 8'h42},
      '{8'h41, 8'h42, 8'h58, 8'h58, 8'h58}, 16'h0005);
    run(1'b1, 16'h0002, 16'h0300, 16'h0000, '{8'h41},
      '{8'h41, 8'h0D, 8'h0A, 8'h0D, 8'h0A}, 16'h0005);
    run(1'b1, 16'h0001, 16'h0200, 16'h0000, '{8'h41}, '{8'h41, 8'h0A}, 16'h0002);
    run(1'b1, 16'h5800, 16'h0300, 16'h0000, '{8'h41}, '{8'h41}, 16'h0001);
    run(1'b1, 16'h0000, 16'h0200, 16'h0000, '{8'h41, 8'h0D, 8'h0A, 8'h42, 8'h0C},
      '{8'h41, 8'h0D, 8'h0A, 8'h42, 8'h0D, 8'h0C}, 16'h0006);
    run(1'b1, 16'h0000, 16'h0300, 16'h0000, '{8'h81, 8'h41}, '{8'h41}, 16'h0001);
    run(1'b1, 16'h0000, 16'h0700, 16'h0000, '{8'h81, 8'h41},
      '{8'h81, 8'h41}, 16'h0002);
    run(1'b1, 16'h0000, 16'h0B00, 16'h0000, '{8'h81, 8'h41},
      '{8'h81, 8'h41}, 16'h0002);
    // The column carries over between buffers, so each wrap run opens with a return.
    run(1'b1, 16'h0000, 16'h1300, 16'h0200, '{8'h0D, 8'h41, 8'h42, 8'h43},
      '{8'h0D, 8'h41, 8'h42, 8'h0A, 8'h43}, 16'h0005);
    run(1'b1, 16'h0000, 16'h1200, 16'h0200, '{8'h0A, 8'h41, 8'h42, 8'h43},
      '{8'h0D, 8'h0A, 8'h41, 8'h42, 8'h0D, 8'h0A, 8'h43}, 16'h0007);
    // A slow printer lets the buffer back up, though at this length it never fills or refuses.
    for (int i = 0; i < 24; i++) raw.push_back(8'h40 + 8'(i));
    slow = 1'b1;
    run(1'b0, 16'h5802, 16'h0000, 16'h0000, raw, raw, 16'h0018);
    slow = 1'b0;
    run(1'b0, 16'h5802, 16'h0000, 16'h0000, none, none, 16'h0000);
    wrap_up();
  end
endmodule
